// ---- verilog/swd_pkg.sv ----
// constants and types of the sleep-mode and watchdog block
package swd_pkg;

	// -----------------------------------------------------------------
	// cpu opcodes seen by the block
	// -----------------------------------------------------------------
	localparam logic [7:0]  OP_NOP      = 8'hFF;
	localparam logic [7:0]  OP_STOP     = 8'h6F;
	localparam logic [7:0]  OP_HALT     = 8'h7F;
	localparam logic [7:0]  OP_WDT      = 8'h5F;
	localparam logic [7:0]  OP_WDH      = 8'h4F;

	// -----------------------------------------------------------------
	// reset and watchdog timing
	// -----------------------------------------------------------------
	localparam logic [15:0] STOP_RCV_VEC   = 16'h000C;
	localparam int          WDT_XTAL_EXTRA = 18;
	localparam int          CW             = 24;
	localparam int          WDT_PERIOD_DEF = 65536;
	localparam int          POR_DELAY_DEF  = 1024;

	// -----------------------------------------------------------------
	// register map (byte addresses, one word each)
	// -----------------------------------------------------------------
	localparam int          AW         = 4;
	localparam int          DW         = 32;
	localparam logic [3:0]  REG_STATUS = 4'h0;
	localparam logic [3:0]  REG_EVT    = 4'h4;
	localparam logic [3:0]  REG_MASK   = 4'h8;
	localparam logic [3:0]  REG_WCNT   = 4'hC;

	// event bits, shared by event and mask registers
	localparam int          NEV        = 4;
	localparam int          EV_HALT    = 0;
	localparam int          EV_STOP    = 1;
	localparam int          EV_WDT     = 2;
	localparam int          EV_LVD     = 3;
	localparam logic [3:0]  MASK_RST   = 4'h0;

	// status bits
	localparam int          SB_HALT    = 0;
	localparam int          SB_STOP    = 1;
	localparam int          SB_RST     = 2;
	localparam int          SB_WEN     = 3;
	localparam int          SB_PERM    = 4;
	localparam int          SB_HWEN    = 5;

	// flag values after a refresh: {zero, sign, overflow}
	localparam logic [2:0]  FLAGS_WDT  = 3'h4;

	typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STOP, ST_RST} swd_state_t;
	typedef enum logic {RK_FULL, RK_STOP} swd_rkind_t;

endpackage : swd_pkg

// ---- verilog/swd_sync3.sv ----
// three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/1ps
module swd_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	input  wire logic i_async,
	output logic      o_sync
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// shift chain; only the second and third stages are compared
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			s1_r   <= RST_VAL;
			s2_r   <= RST_VAL;
			s3_r   <= RST_VAL;
			o_sync <= RST_VAL;
		end
		else
		begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				o_sync <= s3_r;
		end
	end
endmodule : swd_sync3

// ---- verilog/swd_counter.sv ----
// up counter with synchronous clear and count enable
`timescale 1ns/1ps
module swd_counter #(
	parameter int W = 24
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_clr,
	input  wire logic         i_en,
	output logic [W-1:0]      o_q
);
	// clear beats count so a refresh never loses to a tick
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n || i_clr)
			o_q <= '0;
		else if (i_en)
			o_q <= o_q + W'(1);
	end
endmodule : swd_counter

// ---- verilog/swd_sleep_wdt.sv ----
// sleep control, stop recovery, watchdog and reset sequencer
`timescale 1ns/1ps
module swd_sleep_wdt
	import swd_pkg::*;
#(
	parameter int WDT_PERIOD_CYC = swd_pkg::WDT_PERIOD_DEF,
	parameter int POR_DELAY_CYC  = swd_pkg::POR_DELAY_DEF
) (
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_rst_n,
	input  wire logic [swd_pkg::AW-1:0] i_avs_address,
	input  wire logic                 i_avs_read,
	input  wire logic                 i_avs_write,
	input  wire logic [swd_pkg::DW-1:0] i_avs_writedata,
	output logic      [swd_pkg::DW-1:0] o_avs_readdata,
	output logic                      o_avs_waitrequest,
	input  wire logic                 i_op_valid,
	input  wire logic [7:0]           i_opcode,
	input  wire logic                 i_irq_taken,
	input  wire logic                 i_stop_recovery_pin,
	input  wire logic                 i_below_auto_reset_threshold,
	input  wire logic                 i_perm_wdt_opt,
	output logic                      o_cpu_clk_en,
	output logic                      o_osc_en,
	output logic                      o_periph_clk_en,
	output logic                      o_sys_rst,
	output logic                      o_port_mode_rst,
	output logic                      o_vec_load,
	output logic      [15:0]          o_vec_addr,
	output logic                      o_flags_we,
	output logic      [2:0]           o_flags_zsv,
	output logic                      o_irq
);
	import swd_pkg::*;

	localparam logic [CW-1:0] WDT_LAST  = CW'(WDT_PERIOD_CYC - 1);
	localparam logic [CW-1:0] POR_LIM   = CW'(POR_DELAY_CYC);
	localparam logic [CW-1:0] WDT_RLIM  = CW'(POR_DELAY_CYC + WDT_XTAL_EXTRA);

	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	swd_state_t      state_r;
	swd_state_t      state_nxt;
	swd_rkind_t      rkind_r;
	logic [CW-1:0]   rst_lim_r;
	logic [CW-1:0]   rst_cnt;
	logic [CW-1:0]   wdt_cnt;
	logic            perm_r;
	logic            strap_done_r;
	logic            sw_en_r;
	logic            halt_en_r;
	logic            wdt_en;
	logic            wdt_run;
	logic            wdt_clr;
	logic            wdt_to;
	logic            rst_last;
	logic            pin_s;
	logic            lvd_s;
	logic            lvd_d_r;
	logic            op_ok;
	logic            op_wdt;
	logic            op_wdh;
	logic            ack_r;
	logic            bus_req;
	logic            wr_fire;
	logic [NEV-1:0]  evt_r;
	logic [NEV-1:0]  mask_r;
	logic [NEV-1:0]  ev_set;
	logic [DW-1:0]   rd_mux;

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	// the pad input buffer is sampled, so output mode does not mask it
	swd_sync3 #(
		.RST_VAL (1'b1)
	) u_pin_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_stop_recovery_pin),
		.o_sync    (pin_s)
	);

	swd_sync3 #(
		.RST_VAL (1'b0)
	) u_lvd_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (i_below_auto_reset_threshold),
		.o_sync    (lvd_s)
	);

	// -----------------------------------------------------------------
	// opcode decode and permanent option strap
	// -----------------------------------------------------------------
	// opcodes count only while the cpu actually runs; the caller is
	// trusted to flush the pipeline with a no-op first
	assign op_ok  = i_op_valid && (state_r == ST_RUN);
	assign op_wdt = op_ok && (i_opcode == OP_WDT);
	assign op_wdh = op_ok && (i_opcode == OP_WDH);

	// strap caught once, on the first clock after reset release
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			perm_r       <= 1'b0;
			strap_done_r <= 1'b0;
		end
		else if (!strap_done_r)
		begin
			perm_r       <= i_perm_wdt_opt;
			strap_done_r <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// watchdog enables
	// -----------------------------------------------------------------
	// software enable survives everything but an external or internal reset
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n || state_r == ST_RST)
			sw_en_r <= 1'b0;
		else if (op_wdt)
			sw_en_r <= 1'b1;
	end

	// halt run permission needs an already enabled watchdog
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n || state_r == ST_RST)
			halt_en_r <= 1'b0;
		else if (op_wdh && wdt_en)
			halt_en_r <= 1'b1;
	end

	assign wdt_en = sw_en_r || perm_r;

	// counting window per mode; permanent mode ignores sleep
	always_comb
	begin
		unique case (state_r)
			ST_RUN:  wdt_run = wdt_en;
			ST_HALT: wdt_run = wdt_en && (perm_r || halt_en_r);
			ST_STOP: wdt_run = perm_r;
			ST_RST:  wdt_run = 1'b0;
		endcase
	end

	// refresh clears; the first refresh also starts from zero
	assign wdt_clr = (state_r == ST_RST) || op_wdt;
	assign wdt_to  = wdt_run && !op_wdt && (wdt_cnt == WDT_LAST);

	swd_counter #(
		.W (CW)
	) u_wdt_cnt (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_clr     (wdt_clr),
		.i_en      (wdt_run),
		.o_q       (wdt_cnt)
	);

	// -----------------------------------------------------------------
	// reset length counter
	// -----------------------------------------------------------------
	// held at zero while the supply is low, so the delay starts at recovery
	swd_counter #(
		.W (CW)
	) u_rst_cnt (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_clr     ((state_r != ST_RST) || lvd_s),
		.i_en      (state_r == ST_RST),
		.o_q       (rst_cnt)
	);

	assign rst_last = (rst_cnt == rst_lim_r - CW'(1));

	// -----------------------------------------------------------------
	// mode sequencer
	// -----------------------------------------------------------------
	// supply loss outranks everything, then watchdog timeout
	always_comb
	begin
		state_nxt = state_r;
		if (lvd_s)
			state_nxt = ST_RST;
		else if (wdt_to)
			state_nxt = ST_RST;
		else
		begin
			unique case (state_r)
				ST_RUN:
				begin
					if (op_ok && i_opcode == OP_HALT)
						state_nxt = ST_HALT;
					else if (op_ok && i_opcode == OP_STOP)
						state_nxt = ST_STOP;
				end
				ST_HALT:
				begin
					if (i_irq_taken)
						state_nxt = ST_RUN;
				end
				ST_STOP:
				begin
					if (!pin_s)
						state_nxt = ST_RST;
				end
				ST_RST:
				begin
					if (rst_last)
						state_nxt = ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			state_r <= ST_RST;
		else
			state_r <= state_nxt;
	end

	// reset kind and length chosen on entry; stop recovery spares ports
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			rkind_r   <= RK_FULL;
			rst_lim_r <= POR_LIM;
		end
		else if (lvd_s)
		begin
			rkind_r   <= RK_FULL;
			rst_lim_r <= POR_LIM;
		end
		else if (wdt_to)
		begin
			rkind_r   <= RK_FULL;
			rst_lim_r <= WDT_RLIM;
		end
		else if (state_r == ST_STOP && !pin_s)
		begin
			rkind_r   <= RK_STOP;
			rst_lim_r <= POR_LIM;
		end
	end

	// -----------------------------------------------------------------
	// clock gates and reset outputs
	// -----------------------------------------------------------------
	assign o_cpu_clk_en    = (state_r == ST_RUN);
	assign o_osc_en        = (state_r != ST_STOP);
	assign o_periph_clk_en = (state_r == ST_RUN) || (state_r == ST_HALT);
	assign o_sys_rst       = (state_r == ST_RST);
	assign o_port_mode_rst = (state_r == ST_RST) && (rkind_r == RK_FULL);
	assign o_vec_addr      = STOP_RCV_VEC;

	// vector load pulses in the first run cycle after a stop recovery
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			o_vec_load <= 1'b0;
		else
			o_vec_load <= (state_r == ST_RST) && (state_nxt == ST_RUN)
				&& (rkind_r == RK_STOP);
	end

	// flag update pulse after each refresh opcode
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			o_flags_we  <= 1'b0;
			o_flags_zsv <= '0;
		end
		else
		begin
			o_flags_we  <= op_wdt;
			o_flags_zsv <= op_wdt ? FLAGS_WDT : '0;
		end
	end

	// -----------------------------------------------------------------
	// events and interrupt
	// -----------------------------------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			lvd_d_r <= 1'b0;
		else
			lvd_d_r <= lvd_s;
	end

	always_comb
	begin
		ev_set          = '0;
		ev_set[EV_HALT] = (state_r == ST_HALT) && (state_nxt == ST_RUN);
		ev_set[EV_STOP] = (state_r == ST_STOP) && !pin_s && !lvd_s && !wdt_to;
		ev_set[EV_WDT]  = wdt_to && !lvd_s;
		ev_set[EV_LVD]  = lvd_s && !lvd_d_r;
	end

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			evt_r <= '0;
		else if (wr_fire && i_avs_address == REG_EVT)
			evt_r <= (evt_r & ~i_avs_writedata[NEV-1:0]) | ev_set;
		else
			evt_r <= evt_r | ev_set;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			mask_r <= MASK_RST;
		else if (wr_fire && i_avs_address == REG_MASK)
			mask_r <= i_avs_writedata[NEV-1:0];
	end

	assign o_irq = |(evt_r & mask_r);

	// -----------------------------------------------------------------
	// avalon slave: one wait state per access
	// -----------------------------------------------------------------
	assign bus_req           = i_avs_read || i_avs_write;
	assign o_avs_waitrequest = bus_req && !ack_r;
	assign wr_fire           = i_avs_write && ack_r;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= bus_req && !ack_r;
	end

	// unmapped or misaligned addresses read zero
	always_comb
	begin
		rd_mux = '0;
		unique case (i_avs_address)
			REG_STATUS:
			begin
				rd_mux[SB_HALT] = (state_r == ST_HALT);
				rd_mux[SB_STOP] = (state_r == ST_STOP);
				rd_mux[SB_RST]  = (state_r == ST_RST);
				rd_mux[SB_WEN]  = wdt_en;
				rd_mux[SB_PERM] = perm_r;
				rd_mux[SB_HWEN] = halt_en_r;
			end
			REG_EVT:  rd_mux[NEV-1:0] = evt_r;
			REG_MASK: rd_mux[NEV-1:0] = mask_r;
			REG_WCNT: rd_mux[CW-1:0]  = wdt_cnt;
			default:  rd_mux = '0;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			o_avs_readdata <= '0;
		else if (i_avs_read && !ack_r)
			o_avs_readdata <= rd_mux;
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	property p_halt_clk;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state_r == ST_HALT) |-> (!o_cpu_clk_en && o_osc_en && o_periph_clk_en);
	endproperty
	a_halt_clk: assert property (p_halt_clk) else $error("halt clock gating wrong");

	property p_halt_exit;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state_r == ST_HALT && !lvd_s && !wdt_to)
			|=> ($past(i_irq_taken) ? state_r == ST_RUN : state_r == ST_HALT);
	endproperty
	a_halt_exit: assert property (p_halt_exit) else $error("halt exit wrong");

	property p_stop_osc;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state_r == ST_STOP) |-> (!o_osc_en && !o_cpu_clk_en && !o_periph_clk_en);
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("stop left a clock on");

	property p_stop_wake;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state_r == ST_STOP && !pin_s && !lvd_s && !wdt_to)
			|=> (o_sys_rst && !o_port_mode_rst);
	endproperty
	a_stop_wake: assert property (p_stop_wake) else $error("stop recovery wrong");

	property p_vec;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		($fell(o_sys_rst) && rkind_r == RK_STOP)
			|-> (o_vec_load && o_vec_addr == STOP_RCV_VEC) ##1 !o_vec_load;
	endproperty
	a_vec: assert property (p_vec) else $error("recovery vector missing");

	property p_port_keep;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_sys_rst && !$past(lvd_s) && (($past(state_r) == ST_STOP && !$past(wdt_to))
			|| ($past(o_sys_rst) && !$past(o_port_mode_rst)))) |-> !o_port_mode_rst;
	endproperty
	a_port_keep: assert property (p_port_keep) else $error("port modes reset");

	property p_wdt_stay;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wdt_en && state_nxt != ST_RST) |=> wdt_en;
	endproperty
	a_wdt_stay: assert property (p_wdt_stay) else $error("watchdog stopped");

	property p_wdt_clear;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		op_wdt |=> (wdt_cnt == '0 && wdt_en);
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("refresh missed");

	property p_wdt_to;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wdt_run && wdt_cnt == WDT_LAST && !op_wdt) |=> o_sys_rst && o_port_mode_rst;
	endproperty
	a_wdt_to: assert property (p_wdt_to) else $error("no timeout reset");

	property p_flags;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		op_wdt |=> (o_flags_we && o_flags_zsv == FLAGS_WDT) ##1 !o_flags_we;
	endproperty
	a_flags: assert property (p_flags) else $error("refresh flags wrong");

	property p_rst_len;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		$fell(o_sys_rst) |-> $past(rst_last);
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset length wrong");

	property p_stop_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state_r == ST_STOP && !perm_r) |=> $stable(wdt_cnt);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("counted in stop");

	property p_halt_hold;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(state_r == ST_HALT && !perm_r && !halt_en_r) |=> $stable(wdt_cnt);
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("counted in halt");

	property p_wdh_noop;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(op_wdh && !wdt_en && !halt_en_r) |=> !halt_en_r;
	endproperty
	a_wdh_noop: assert property (p_wdh_noop) else $error("halt enable leaked");

	property p_perm;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		(perm_r && state_r != ST_RST) |-> (wdt_run && wdt_en);
	endproperty
	a_perm: assert property (p_perm) else $error("permanent watchdog idle");

	property p_lvd;
		@(posedge i_ref_clk) disable iff (!i_rst_n)
		lvd_s |=> (o_sys_rst && o_port_mode_rst && rst_cnt == '0);
	endproperty
	a_lvd: assert property (p_lvd) else $error("low supply without reset");

	c_halt_wake: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		state_r == ST_HALT ##1 state_r == ST_RUN);
	c_stop_rcv:  cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_vec_load);
	c_wdt_to:    cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		wdt_to);
	c_irq:       cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_irq);

endmodule : swd_sleep_wdt

// ---- tb/swd_cpu_model.sv ----
// cpu decoder and wake pin model facing the sleep and watchdog block
`timescale 1ns/1ps
module swd_cpu_model
	import swd_pkg::*;
(
	input  wire logic       i_ref_clk,
	output logic            o_op_valid,
	output logic [7:0]      o_opcode,
	output logic            o_irq_taken,
	output logic            o_pin
);
	// the wake pin idles high through its pull-up
	initial
	begin
		o_op_valid  = 1'b0;
		o_opcode    = 8'h00;
		o_irq_taken = 1'b0;
		o_pin       = 1'b1;
	end

	// a no-op flushes the pipe right before stop or halt
	task automatic exec(input logic [7:0] op);
		@(posedge i_ref_clk);
		if (op == OP_STOP || op == OP_HALT)
		begin
			o_op_valid <= 1'b1;
			o_opcode   <= OP_NOP;
			@(posedge i_ref_clk);
		end
		o_op_valid <= 1'b1;
		o_opcode   <= op;
		@(posedge i_ref_clk);
		o_op_valid <= 1'b0;
		o_opcode   <= ~op; // bus not held once the slot is over
	endtask : exec

	// one-cycle taken strobe of an enabled interrupt
	task automatic irq();
		@(posedge i_ref_clk);
		o_irq_taken <= 1'b1;
		@(posedge i_ref_clk);
		o_irq_taken <= 1'b0;
	endtask : irq

	task automatic pin(input logic lvl);
		@(posedge i_ref_clk);
		o_pin <= lvl;
	endtask : pin
endmodule : swd_cpu_model

// ---- tb/swd_sleep_wdt_test.sv ----
// self-checking bench for the sleep-mode and watchdog block
`timescale 1ns/1ps
module swd_sleep_wdt_test;
	import swd_pkg::*;
	localparam int WP = 64;
	localparam int PD = 8;
	logic        i_ref_clk = 1'b0, i_rst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic [3:0]  i_avs_address = 4'h0, exp_evt = 4'h0, m = 4'h0;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q, lfsr = 32'hD232;
	logic        i_below_auto_reset_threshold = 1'b0, i_perm_wdt_opt = 1'b0;
	logic        i_op_valid, i_irq_taken, i_stop_recovery_pin, o_avs_waitrequest, o_irq;
	logic        o_cpu_clk_en, o_osc_en, o_periph_clk_en, o_sys_rst, o_port_mode_rst;
	logic        o_vec_load, o_flags_we;
	logic [7:0]  i_opcode;
	logic [15:0] o_vec_addr;
	logic [2:0]  o_flags_zsv;
	int          n_fail = 0, check_count = 0, n_flags = 0, n;

	always #10 i_ref_clk = ~i_ref_clk;

	swd_sleep_wdt #(.WDT_PERIOD_CYC(WP), .POR_DELAY_CYC(PD)) u_swd_sleep_wdt (
		.i_ref_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
		.o_avs_readdata, .o_avs_waitrequest, .i_op_valid, .i_opcode, .i_irq_taken,
		.i_stop_recovery_pin, .i_below_auto_reset_threshold, .i_perm_wdt_opt, .o_cpu_clk_en,
		.o_osc_en, .o_periph_clk_en, .o_sys_rst, .o_port_mode_rst, .o_vec_load, .o_vec_addr,
		.o_flags_we, .o_flags_zsv, .o_irq);
	swd_cpu_model u_swd_cpu_model (.i_ref_clk, .o_op_valid(i_op_valid), .o_opcode(i_opcode),
		.o_irq_taken(i_irq_taken), .o_pin(i_stop_recovery_pin));

	// ----------
	// helpers
	// ----------
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_step

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : check

	task automatic tick(input int c);
		repeat (c) @(posedge i_ref_clk);
		#1;
	endtask : tick

	// request held up to the rising edge that samples waitrequest low; data taken there
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge i_ref_clk);
		i_avs_address   <= a;
		i_avs_writedata <= d;
		i_avs_write     <= wr;
		i_avs_read      <= !wr;
		do
		begin
			@(posedge i_ref_clk);
			k++;
		end
		while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read  <= 1'b0;
		check("bus wait states", k, 2);
	endtask : bus

	task automatic wait_rst(input logic lvl, input int lo, input int hi, output int k);
		k = 0;
		while (o_sys_rst !== lvl && k < hi)
		begin
			tick(1);
			k++;
		end
		check("reset timing", o_sys_rst === lvl && k >= lo, 1);
	endtask : wait_rst

	task automatic quiet(input int c);
		int h;
		h = 0;
		repeat (c)
		begin
			tick(1);
			h += (o_sys_rst !== 1'b0);
		end
		check("no reset", h, 0);
	endtask : quiet

	// compare sticky events and the interrupt line with the model, then clear
	task automatic evt();
		bus(0, REG_EVT, 0);
		check("events", q, {28'h0, exp_evt});
		check("irq", o_irq, |(exp_evt & m));
		bus(1, REG_EVT, 32'hF);
		exp_evt = 4'h0;
		tick(1);
		check("irq cleared", o_irq, 0);
	endtask : evt

	always @(posedge i_ref_clk)
		if (o_flags_we === 1'b1)
		begin
			n_flags++;
			check("refresh flags", o_flags_zsv, 3'h4);
		end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	initial
	begin
		#100000;
		n_fail++;
		give_verdict();
	end

	// ----------
	// main sequence
	// ----------
	initial
	begin
		repeat (8) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		wait_rst(0, PD, 40, n);
		bus(0, REG_MASK, 0);
		check("mask reset", q, 0);
		m = lfsr[3:0] | 4'h1; // halt wake always unmasked
		bus(1, REG_MASK, {28'h0, m});
		bus(1, 4'h9, {28'h0, ~m});
		bus(0, REG_MASK, 0);
		check("mask", q, {28'h0, m});
		u_swd_cpu_model.exec(OP_WDH);
		repeat (4)
		begin
			u_swd_cpu_model.exec(OP_WDT);
			lfsr = lfsr_step(lfsr);
			quiet(20 + lfsr[4:0]);
		end
		bus(0, REG_STATUS, 0);
		check("status", q, 32'h1 << SB_WEN);
		u_swd_cpu_model.exec(OP_HALT);
		tick(1);
		check("halt clocks", {o_cpu_clk_en, o_osc_en, o_periph_clk_en}, 3'b011);
		quiet(100);
		u_swd_cpu_model.irq();
		tick(2);
		check("halt wake", o_cpu_clk_en, 1);
		exp_evt[EV_HALT] = 1'b1;
		evt();
		u_swd_cpu_model.exec(OP_WDT);
		u_swd_cpu_model.exec(OP_WDH);
		u_swd_cpu_model.exec(OP_HALT);
		wait_rst(1, WP - 16, WP + 8, n);
		check("full reset", o_port_mode_rst, 1);
		wait_rst(0, 1, 100, n);
		check("timeout reset length", n, PD + 18);
		exp_evt[EV_WDT] = 1'b1;
		evt();
		u_swd_cpu_model.exec(OP_WDT);
		u_swd_cpu_model.exec(OP_STOP);
		tick(1);
		check("stop clocks", {o_cpu_clk_en, o_osc_en}, 0);
		quiet(100);
		u_swd_cpu_model.pin(1'b0);
		wait_rst(1, 1, 10, n);
		check("port modes kept", o_port_mode_rst, 0);
		u_swd_cpu_model.pin(1'b1);
		n = 0;
		while (o_vec_load !== 1'b1 && n < 40)
		begin
			tick(1);
			n++;
		end
		check("recovery vector", {o_sys_rst, o_vec_load, o_vec_addr}, {2'b01, 16'h000C});
		exp_evt[EV_STOP] = 1'b1;
		evt();
		@(posedge i_ref_clk);
		i_below_auto_reset_threshold <= 1'b1;
		wait_rst(1, 1, 10, n);
		tick(30);
		check("supply reset held", {o_sys_rst, o_port_mode_rst}, 2'b11);
		@(posedge i_ref_clk);
		i_below_auto_reset_threshold <= 1'b0;
		wait_rst(0, PD, PD + 12, n);
		exp_evt[EV_LVD] = 1'b1;
		evt();
		@(posedge i_ref_clk);
		i_rst_n        <= 1'b0;
		i_perm_wdt_opt <= 1'b1;
		m = 4'h0;
		tick(4);
		@(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		wait_rst(0, PD, 40, n);
		bus(0, REG_STATUS, 0);
		check("permanent", q[SB_PERM], 1);
		u_swd_cpu_model.exec(OP_STOP);
		wait_rst(1, 24, WP + 8, n);
		wait_rst(0, 1, 100, n);
		check("permanent reset length", n, PD + 18);
		exp_evt = 4'h4;
		evt();
		check("refresh count", n_flags, 6);
		give_verdict();
	end
endmodule : swd_sleep_wdt_test
